//--- dsdf_pkg.sv
// Purpose: shared constants and types of the slave diagnostic frame builder
// Assumes: one clock domain, synchronous active-high reset
// Notes: byte positions, bit positions and fixed field values live here only
`default_nettype none

package dsdf_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam logic [3:0] IDX_FIRST = 4'h0;
  localparam logic [3:0] IDX_LAST = 4'hf;
  localparam logic [3:0] B_ST1 = 4'h0;
  localparam logic [3:0] B_ST2 = 4'h1;
  localparam logic [3:0] B_ST3 = 4'h2;
  localparam logic [3:0] B_MADDR = 4'h3;
  localparam logic [3:0] B_ID_HI = 4'h4;
  localparam logic [3:0] B_ID_LO = 4'h5;
  localparam logic [3:0] B_HDR = 4'h6;
  localparam logic [3:0] B_MSG = 4'h7;
  localparam logic [3:0] B_RSV_FIRST = 4'h8;
  localparam logic [3:0] B_RSV_LAST = 4'ha;
  localparam logic [3:0] B_USR_FIRST = 4'hb;
  localparam logic [2:0] USR_IDX_MAX = 3'h4;
  localparam int unsigned USR_LEN = 5;

  // ****************************************
  // station status bit positions
  // ****************************************
  localparam int unsigned ST1_NOT_READY = 1;
  localparam int unsigned ST1_CFG_FAULT = 2;
  localparam int unsigned ST1_EXT_DIAG = 3;
  localparam int unsigned ST1_UNSUPP = 4;
  localparam int unsigned ST1_BAD_PARAM = 6;
  localparam int unsigned ST2_NEED_PARAM = 0;
  localparam int unsigned ST2_STATIC = 1;
  localparam int unsigned ST2_FIX_ONE = 2;
  localparam int unsigned ST2_WD_ON = 3;
  localparam int unsigned ST2_FREEZE = 4;
  localparam int unsigned ST2_SYNC = 5;
  localparam int unsigned ST3_OVERFLOW = 7;

  // ****************************************
  // fixed values and message codes
  // ****************************************
  localparam logic [5:0] HDR_LEN = 6'h0a;
  localparam logic [1:0] HDR_CODE = 2'h0;
  localparam logic [7:0] HDR_BYTE = {HDR_CODE, HDR_LEN};
  localparam logic [7:0] MSG_NONE = 8'h00;
  localparam logic [7:0] MSG_ERR_FIRST = 8'h12;
  localparam logic [7:0] MSG_ERR_LAST = 8'h17;
  localparam logic [7:0] MSG_USER = 8'h40;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int unsigned CTL_START_BIT = 0;
  localparam int unsigned CTL_DELETE_BIT = 1;
  localparam logic [7:0] CTL_IGNORE = 8'h03;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {DSDF_IDLE, DSDF_LOAD, DSDF_SEND} dsdf_state_e;

  typedef struct packed {
    logic not_ready;
    logic cfg_fault;
    logic unsupp;
    logic bad_param;
    logic need_param;
    logic static_diag;
    logic wd_on;
    logic freeze_rx;
    logic sync_rx;
    logic overflow;
    logic [7:0] master_addr;
    logic [15:0] ident;
  } dsdf_stat_s;

  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [7:0] data;
  } dsdf_tx_s;

  typedef struct packed {
    dsdf_state_e st;
    logic [3:0] idx;
    dsdf_stat_s snap;
    logic ext;
    logic [7:0] msg;
    logic usr_valid;
    logic [7:0] err;
    logic pend;
    dsdf_tx_s tx;
  } dsdf_main_s;

  typedef struct packed {
    logic [7:0] prev;
  } dsdf_ctl_s;

  typedef struct packed {
    logic [USR_LEN-1:0][7:0] mem;
    logic [7:0] rd;
  } dsdf_mem_s;

endpackage

`default_nettype wire

//--- dsdf_usr_mem.sv
// Purpose: five-byte store of the user diagnostic bytes
// Assumes: software writes and frame reads share core_clk
// Notes: read data come out of a register, one cycle after the address
`default_nettype none

module dsdf_usr_mem (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // software write port
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [7:0] wdata,
  // frame read port
  input wire logic [2:0] raddr,
  output logic [7:0] rdata
);
  import dsdf_pkg::*;

  dsdf_mem_s s_q, s_d;

  // ****************************************
  // storage
  // ****************************************
  // writes past the last byte are dropped
  always_comb begin
    s_d = s_q;
    if (we && waddr <= USR_IDX_MAX) begin
      s_d.mem[waddr] = wdata;
    end
    s_d.rd = (raddr <= USR_IDX_MAX) ? s_q.mem[raddr] : RST_BYTE;
  end

  // registered state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rd;

endmodule

`default_nettype wire

//--- dsdf_swctl.sv
// Purpose: decode writes of the diagnostic status byte into start/delete
// Assumes: one write strobe per software access
// Notes: an ignored value does not update the remembered byte
`default_nettype none

module dsdf_swctl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // status byte write
  input wire logic we,
  input wire logic [7:0] wdata,
  // decoded events
  output logic start,
  output logic delete
);
  import dsdf_pkg::*;

  dsdf_ctl_s s_q, s_d;
  logic take;

  // ****************************************
  // decode
  // ****************************************
  // start only on a rising valid bit, never on the ignored pattern
  always_comb begin
    s_d = s_q;
    take = we && (wdata != CTL_IGNORE);
    start = take && wdata[CTL_START_BIT] && !s_q.prev[CTL_START_BIT];
    delete = take && wdata[CTL_DELETE_BIT];
    if (take) begin
      s_d.prev = wdata;
    end
  end

  // registered state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

`default_nettype wire

//--- dsdf_frame.sv
// Purpose: build and stream the 16-byte slave diagnostic response
// Assumes: master-side link pulls bytes with tx_ready, same clock
// Notes: status is frozen at frame start so a frame is self-consistent
//
// Operation
// - send on master request or own error
// - standard bytes 0-5, device bytes 6-15
// - bytes 11-15 from software-written store
// - status1 bit1 while not ready
// - status1 bit2 on configuration mismatch
// - status1 bit3 when external diagnostic valid
// - status1 bit4 on unsupported function
// - status1 bit6 bad parameters, bits0,5,7 zero
// - status2 bit0 when new parameters needed
// - status2 bit1 static, bit2 one, bit7 zero
// - status2 bit3 while watchdog monitoring active
// - status2 bit4 after freeze command
// - status2 bit5 after sync command
// - status3 bit7 on overflow, rest reserved
// - byte3 is parametrizing master address
// - byte6 header, byte7 message, 8-10 reserved
// - header is length ten, code zero
// - message 12h-17h errors, 40h user data
// - rising start bit sends diagnostic
// - delete bit clears; value 03h ignored
`default_nettype none

module dsdf_frame (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // live slave status
  input wire dsdf_pkg::dsdf_stat_s stat,
  // master diagnostic request
  input wire logic diag_req,
  // local error event
  input wire logic err_evt,
  input wire logic [7:0] err_code,
  // software diagnostic status byte
  input wire logic ctl_we,
  input wire logic [7:0] ctl_wdata,
  // software user bytes
  input wire logic usr_we,
  input wire logic [2:0] usr_idx,
  input wire logic [7:0] usr_wdata,
  // byte stream to the bus side
  output dsdf_pkg::dsdf_tx_s tx,
  input wire logic tx_ready,
  // state seen by software
  output logic busy,
  output logic usr_valid
);
  import dsdf_pkg::*;

  dsdf_main_s s_q, s_d;
  logic sw_start, sw_delete, err_ok, trig, go;
  logic [7:0] usr_rd;

  // ****************************************
  // helpers
  // ****************************************
  // only documented error codes are latched
  function automatic logic is_err(input logic [7:0] c);
    return (c >= MSG_ERR_FIRST) && (c <= MSG_ERR_LAST);
  endfunction

  // frame index to user store address
  function automatic logic [2:0] usr_addr(input logic [3:0] i);
    logic [3:0] t;
    t = i - B_USR_FIRST;
    return t[2:0];
  endfunction

  // one response byte from the frozen snapshot
  function automatic logic [7:0] frame_byte(input logic [3:0] i, input dsdf_stat_s s,
                                            input logic ext, input logic [7:0] msg,
                                            input logic [7:0] ud);
    logic [7:0] b;
    b = RST_BYTE;
    case (i)
      B_ST1: begin
        b[ST1_NOT_READY] = s.not_ready;
        b[ST1_CFG_FAULT] = s.cfg_fault;
        b[ST1_EXT_DIAG] = ext;
        b[ST1_UNSUPP] = s.unsupp;
        b[ST1_BAD_PARAM] = s.bad_param;
      end
      B_ST2: begin
        b[ST2_NEED_PARAM] = s.need_param;
        b[ST2_STATIC] = s.static_diag;
        b[ST2_FIX_ONE] = 1'b1;
        b[ST2_WD_ON] = s.wd_on;
        b[ST2_FREEZE] = s.freeze_rx;
        b[ST2_SYNC] = s.sync_rx;
      end
      B_ST3: b[ST3_OVERFLOW] = s.overflow;
      B_MADDR: b = s.master_addr;
      B_ID_HI: b = s.ident[15:8];
      B_ID_LO: b = s.ident[7:0];
      B_HDR: b = HDR_BYTE;
      B_MSG: b = msg;
      default: begin
        // reserved bytes stay zero, user bytes come from the store
        if (i >= B_USR_FIRST) begin
          b = ud;
        end
      end
    endcase
    return b;
  endfunction

  // ****************************************
  // submodules
  // ****************************************
  dsdf_swctl u_swctl (
    .core_clk(core_clk),
    .rst(rst),
    .we(ctl_we),
    .wdata(ctl_wdata),
    .start(sw_start),
    .delete(sw_delete)
  );

  // read address follows the next index so data wait in LOAD
  dsdf_usr_mem u_mem (
    .core_clk(core_clk),
    .rst(rst),
    .we(usr_we),
    .waddr(usr_idx),
    .wdata(usr_wdata),
    .raddr(usr_addr(s_d.idx)),
    .rdata(usr_rd)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    err_ok = err_evt && is_err(err_code);
    trig = diag_req || err_ok || sw_start;
    go = 1'b0;
    // user data validity: a start wins over a delete
    if (sw_start) begin
      s_d.usr_valid = 1'b1;
    end else if (sw_delete) begin
      s_d.usr_valid = 1'b0;
    end
    // error latch: a new error wins over a delete
    if (err_ok) begin
      s_d.err = err_code;
    end else if (sw_delete) begin
      s_d.err = MSG_NONE;
    end
    case (s_q.st)
      DSDF_IDLE: begin
        if (trig || s_q.pend) begin
          go = 1'b1;
          s_d.st = DSDF_LOAD;
          s_d.idx = IDX_FIRST;
          s_d.snap = stat;
          s_d.ext = s_d.usr_valid || (s_d.err != MSG_NONE);
          // errors take priority over the user message
          if (s_d.err != MSG_NONE) begin
            s_d.msg = s_d.err;
          end else if (s_d.usr_valid) begin
            s_d.msg = MSG_USER;
          end else begin
            s_d.msg = MSG_NONE;
          end
        end
      end
      DSDF_LOAD: begin
        s_d.tx.valid = 1'b1;
        s_d.tx.first = (s_q.idx == IDX_FIRST);
        s_d.tx.last = (s_q.idx == IDX_LAST);
        s_d.tx.data = frame_byte(s_q.idx, s_q.snap, s_q.ext, s_q.msg, usr_rd);
        s_d.st = DSDF_SEND;
      end
      DSDF_SEND: begin
        if (tx_ready) begin
          s_d.tx.valid = 1'b0;
          if (s_q.tx.last) begin
            s_d.st = DSDF_IDLE;
          end else begin
            s_d.idx = s_q.idx + 4'h1;
            s_d.st = DSDF_LOAD;
          end
        end
      end
      default: s_d.st = DSDF_IDLE;
    endcase
    // a trigger during a frame is kept for one more frame
    s_d.pend = (s_q.pend && !go) || (trig && !go);
  end

  // registered state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs all from flops
  assign tx = s_q.tx;
  assign busy = (s_q.st != DSDF_IDLE);
  assign usr_valid = s_q.usr_valid;

  // ****************************************
  // assertions
  // ****************************************
  // every check runs on core_clk and stays quiet while reset is held
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_req_send;
    (s_q.st == DSDF_IDLE) && diag_req |-> ##2 tx.valid && tx.first;
  endproperty
  a_req_send: assert property (p_req_send) else $error("request not answered");

  property p_err_send;
    (s_q.st == DSDF_IDLE) && err_ok |-> ##2 tx.valid && tx.first &&
      (s_q.msg == $past(err_code, 2));
  endproperty
  a_err_send: assert property (p_err_send) else $error("error not sent");

  property p_last_idx;
    tx.valid && tx.last |-> (s_q.idx == IDX_LAST) && !tx.first;
  endproperty
  a_last_idx: assert property (p_last_idx) else $error("frame length wrong");

  property p_st1_fix;
    tx.valid && (s_q.idx == B_ST1) |-> !tx.data[0] && !tx.data[5] && !tx.data[7];
  endproperty
  a_st1_fix: assert property (p_st1_fix) else $error("status1 fixed bits");

  property p_st1_ext;
    tx.valid && (s_q.idx == B_ST1) |-> tx.data[ST1_EXT_DIAG] == (s_q.msg != MSG_NONE);
  endproperty
  a_st1_ext: assert property (p_st1_ext) else $error("ext diag bit wrong");

  property p_st2_fix;
    tx.valid && (s_q.idx == B_ST2) |-> tx.data[ST2_FIX_ONE] && !tx.data[7];
  endproperty
  a_st2_fix: assert property (p_st2_fix) else $error("status2 fixed bits");

  property p_maddr;
    tx.valid && (s_q.idx == B_MADDR) |-> tx.data == s_q.snap.master_addr;
  endproperty
  a_maddr: assert property (p_maddr) else $error("master address wrong");

  property p_ident;
    tx.valid && (s_q.idx == B_ID_HI) && tx_ready |-> ##2 tx.data == s_q.snap.ident[7:0];
  endproperty
  a_ident: assert property (p_ident) else $error("ident order wrong");

  property p_hdr;
    tx.valid && (s_q.idx == B_HDR) |-> tx.data == HDR_BYTE;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header byte wrong");

  property p_rsv;
    tx.valid && (s_q.idx >= B_RSV_FIRST) && (s_q.idx <= B_RSV_LAST) |-> tx.data == RST_BYTE;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved byte not zero");

  property p_start;
    (s_q.st == DSDF_IDLE) && sw_start |=> s_q.usr_valid ##1 tx.valid && tx.first;
  endproperty
  a_start: assert property (p_start) else $error("start not sent");

  property p_ignore;
    ctl_we && (ctl_wdata == CTL_IGNORE) && !sw_start |=> $stable(s_q.usr_valid);
  endproperty
  a_ignore: assert property (p_ignore) else $error("ignored value acted");

  property p_hold;
    tx.valid && !tx_ready |=> tx.valid && $stable(tx.data);
  endproperty
  a_hold: assert property (p_hold) else $error("byte dropped under stall");

  // first mark only ever on byte 0
  property p_first_idx;
    tx.valid && tx.first |-> (s_q.idx == IDX_FIRST) && !tx.last;
  endproperty
  a_first_idx: assert property (p_first_idx) else $error("frame start wrong");

  // status1 not-ready, configuration and unsupported bits follow the frozen snapshot
  property p_st1_flags;
    tx.valid && (s_q.idx == B_ST1) |-> (tx.data[ST1_NOT_READY] == s_q.snap.not_ready) &&
      (tx.data[ST1_CFG_FAULT] == s_q.snap.cfg_fault) &&
      (tx.data[ST1_UNSUPP] == s_q.snap.unsupp);
  endproperty
  a_st1_flags: assert property (p_st1_flags) else $error("status1 flags");

  // status2 event bits follow the frozen snapshot
  property p_st2_ev;
    tx.valid && (s_q.idx == B_ST2) |-> (tx.data[ST2_NEED_PARAM] == s_q.snap.need_param) &&
      (tx.data[ST2_WD_ON] == s_q.snap.wd_on) &&
      (tx.data[ST2_FREEZE] == s_q.snap.freeze_rx) && (tx.data[ST2_SYNC] == s_q.snap.sync_rx);
  endproperty
  a_st2_ev: assert property (p_st2_ev) else $error("status2 flags");

  // status3 keeps the reserved bits clear
  property p_st3;
    tx.valid && (s_q.idx == B_ST3) |-> (tx.data[6:0] == 7'h00) &&
      (tx.data[ST3_OVERFLOW] == s_q.snap.overflow);
  endproperty
  a_st3: assert property (p_st3) else $error("status3 wrong");

  // ident high byte leads
  property p_ident_hi;
    tx.valid && (s_q.idx == B_ID_HI) |-> tx.data == s_q.snap.ident[15:8];
  endproperty
  a_ident_hi: assert property (p_ident_hi) else $error("ident high wrong");

  // message byte only ever carries a documented code
  property p_msg_code;
    tx.valid && (s_q.idx == B_MSG) |-> (tx.data == MSG_NONE) || (tx.data == MSG_USER) ||
      ((tx.data >= MSG_ERR_FIRST) && (tx.data <= MSG_ERR_LAST));
  endproperty
  a_msg_code: assert property (p_msg_code) else $error("message code unknown");

  // a lone delete clears both the user mark and the error latch
  property p_delete;
    sw_delete && !sw_start && !err_ok |=> !s_q.usr_valid && (s_q.err == MSG_NONE);
  endproperty
  a_delete: assert property (p_delete) else $error("delete not taken");

  // one empty cycle after each accepted byte while the next is loaded
  property p_gap;
    tx.valid && tx_ready |=> !tx.valid;
  endproperty
  a_gap: assert property (p_gap) else $error("no gap after byte");

  // main scenarios
  c_frame: cover property (tx.valid && tx.last && tx_ready);
  c_err: cover property ((s_q.st == DSDF_IDLE) && err_ok);
  c_pend: cover property (s_q.pend && busy);
  c_del: cover property (sw_delete && s_q.usr_valid);
  c_stall: cover property (tx.valid && !tx_ready ##1 tx.valid && tx_ready);

endmodule

`default_nettype wire

//--- dsdf_master_model.sv
// Purpose: bus-side consumer of the diagnostic byte stream
// Assumes: same clock as the frame builder, synchronous reset
// Notes: slow mode stalls tx_ready three cycles in four
`default_nettype none

module dsdf_master_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pacing
  input wire logic slow,
  // byte stream from the slave
  input wire dsdf_pkg::dsdf_tx_s tx,
  output logic tx_ready,
  // collected frames
  output logic [15:0][7:0] frame,
  output logic [7:0] frames,
  output logic flag_err
);
  timeunit 1ns;
  timeprecision 1ns;
  import dsdf_pkg::*;

  logic [1:0] cnt;
  logic [3:0] idx;

  // pacing: a real master may leave the slave waiting at any byte
  always @(posedge core_clk) begin
    if (rst) begin
      cnt <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      tx_ready <= slow ? (cnt == 2'h0) : 1'b1;
    end
  end

  // capture bytes in order, frame marks must sit on bytes 0 and 15
  always @(posedge core_clk) begin
    if (rst) begin
      idx <= 4'h0;
      frames <= 8'h00;
      flag_err <= 1'b0;
    end else if ((tx.valid === 1'b1) && tx_ready) begin
      frame[idx] <= tx.data;
      if ((tx.first !== (idx == IDX_FIRST)) || (tx.last !== (idx == IDX_LAST))) begin
        flag_err <= 1'b1;
      end
      idx <= idx + 4'h1;
      if (idx == IDX_LAST) begin
        frames <= frames + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

//--- testbench.sv
// Purpose: self-checking bench of the diagnostic frame builder
// Assumes: 20 MHz core_clk, reset held three cycles
// Notes: expected frames are rebuilt here from the bit layout
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dsdf_pkg::*;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  dsdf_stat_s stat = '0;
  logic diag_req = 1'b0;
  logic err_evt = 1'b0;
  logic [7:0] err_code = 8'h00;
  logic ctl_we = 1'b0;
  logic [7:0] ctl_wdata = 8'h00;
  logic usr_we = 1'b0;
  logic [2:0] usr_idx = 3'h0;
  logic [7:0] usr_wdata = 8'h00;
  logic slow = 1'b0;
  dsdf_tx_s tx;
  logic tx_ready, busy, usr_valid, flag_err;
  logic [15:0][7:0] frame;
  logic [7:0] frames, base;
  logic [4:0][7:0] ub = '0;
  int fail_count = 0;
  int checked = 0;

  always #25 core_clk = ~core_clk;

  dsdf_frame uut (.core_clk(core_clk), .rst(rst), .stat(stat), .diag_req(diag_req),
    .err_evt(err_evt), .err_code(err_code), .ctl_we(ctl_we), .ctl_wdata(ctl_wdata),
    .usr_we(usr_we), .usr_idx(usr_idx), .usr_wdata(usr_wdata), .tx(tx),
    .tx_ready(tx_ready), .busy(busy), .usr_valid(usr_valid));

  dsdf_master_model master (.core_clk(core_clk), .rst(rst), .slow(slow), .tx(tx),
    .tx_ready(tx_ready), .frame(frame), .frames(frames), .flag_err(flag_err));

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checked %0d mismatches %0d", checked, fail_count);
    if ((fail_count == 0) && (checked > 0)) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // expected frame from status, message and user bytes
  function automatic logic [15:0][7:0] exp_frame(input dsdf_stat_s s, input logic [7:0] m);
    logic [15:0][7:0] f;
    f = '0;
    f[0] = {1'b0, s.bad_param, 1'b0, s.unsupp, (m != 8'h00), s.cfg_fault, s.not_ready, 1'b0};
    f[1] = {2'b00, s.sync_rx, s.freeze_rx, s.wd_on, 1'b1, s.static_diag, s.need_param};
    f[2] = {s.overflow, 7'h00};
    f[3] = s.master_addr;
    f[4] = s.ident[15:8];
    f[5] = s.ident[7:0];
    f[6] = 8'h0a;
    f[7] = m;
    for (int i = 0; i < 5; i++) f[11 + i] = ub[i];
    return f;
  endfunction

  // frame bytes grouped by the field each one carries
  task automatic check_frame(input logic [7:0] m);
    logic [15:0][7:0] e;
    e = exp_frame(stat, m);
    check("status1", frame[0], e[0]);
    check("status2", frame[1], e[1]);
    check("status3", frame[2], e[2]);
    check("master", frame[3], e[3]);
    check("ident_hi", frame[4], e[4]);
    check("ident_lo", frame[5], e[5]);
    check("header", frame[6], e[6]);
    check("message", frame[7], e[7]);
    for (int i = 8; i < 11; i++) check("reserved", frame[i], 8'h00);
    for (int i = 11; i < 16; i++) check("user", frame[i], e[i]);
  endtask

  // ****************************************
  // access tasks, one-cycle strobes
  // ****************************************
  task automatic req_diag();
    @(posedge core_clk) diag_req <= 1'b1;
    @(posedge core_clk) diag_req <= 1'b0;
  endtask

  task automatic req_err(input logic [7:0] c);
    @(posedge core_clk) begin
      err_evt <= 1'b1;
      err_code <= c;
    end
    @(posedge core_clk) err_evt <= 1'b0;
  endtask

  task automatic ctl_wr(input logic [7:0] v);
    @(posedge core_clk) begin
      ctl_we <= 1'b1;
      ctl_wdata <= v;
    end
    @(posedge core_clk) ctl_we <= 1'b0;
  endtask

  task automatic usr_wr(input logic [2:0] i, input logic [7:0] v);
    @(posedge core_clk) begin
      usr_we <= 1'b1;
      usr_idx <= i;
      usr_wdata <= v;
    end
    @(posedge core_clk) usr_we <= 1'b0;
    ub[i] = v;
  endtask

  // bounded wait for n more complete frames
  task automatic wait_frames(input logic [7:0] n);
    logic [7:0] tgt;
    int k;
    tgt = frames + n;
    k = 0;
    while ((frames !== tgt) && (k < 3000)) begin
      @(posedge core_clk);
      k++;
    end
    check("frames", frames, tgt);
  endtask

  // hang guard, 40000 cycles, generous against the expected several hundred cycles
  initial begin
    #2000000;
    fail_count++;
    results();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    check("usr_valid_rst", {7'h00, usr_valid}, 8'h00);
    // master request, quiet status
    req_diag();
    wait_frames(8'h01);
    check_frame(8'h00);
    $display("test quiet frame done");
    // every status flag set, master stalling
    @(posedge core_clk) begin
      stat <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h5a, 16'h1234};
      slow <= 1'b1;
    end
    req_diag();
    wait_frames(8'h01);
    check_frame(8'h00);
    @(posedge core_clk) slow <= 1'b0;
    $display("test full status done");
    // own error events, each deleted afterwards
    for (int c = 8'h12; c <= 8'h17; c++) begin
      req_err(c[7:0]);
      wait_frames(8'h01);
      check_frame(c[7:0]);
      ctl_wr(8'h02);
    end
    base = frames;
    req_err(8'h18);
    repeat (8) @(posedge core_clk);
    check("busy_bad_code", {7'h00, busy}, 8'h00);
    check("frames_bad_code", frames, base);
    $display("test error codes done");
    // user bytes and the software status byte
    for (int i = 0; i < 5; i++) usr_wr(i[2:0], 8'hc0 + i[7:0]);
    ctl_wr(8'h01);
    wait_frames(8'h01);
    check_frame(8'h40);
    check("usr_valid_set", {7'h00, usr_valid}, 8'h01);
    base = frames;
    ctl_wr(8'h01);
    ctl_wr(8'h03);
    repeat (8) @(posedge core_clk);
    check("frames_no_edge", frames, base);
    check("usr_valid_kept", {7'h00, usr_valid}, 8'h01);
    ctl_wr(8'h02);
    @(posedge core_clk);
    check("usr_valid_del", {7'h00, usr_valid}, 8'h00);
    ctl_wr(8'h01);
    wait_frames(8'h01);
    check_frame(8'h40);
    $display("test software control done");
    // requests during a frame collapse into one extra frame
    base = frames;
    req_diag();
    req_diag();
    req_diag();
    wait_frames(8'h02);
    repeat (40) @(posedge core_clk);
    check("frames_pending", frames, base + 8'h02);
    check("marks", {7'h00, flag_err}, 8'h00);
    $display("test back to back done");
    results();
  end
endmodule

`default_nettype wire
